// >>> dv/ext_source.sv
// model of the external clock or event source driving the count input pin
// assumes the bench calls its task from the clock domain of clk_i
`timescale 1ns/1ns
module ext_source (
    input  wire logic clk_i,
    output logic      count_o
);
    // the pin rests low between bursts; a stopped source does not toggle
    initial begin
        count_o = 1'b0;
    end
    // n full periods, each high then low, every level held for w clocks
    // levels change just after a rising edge, so the synchroniser sees whole levels
    task automatic pulses(input int n, input int w);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            count_o <= 1'b1; // rising edge is the counting edge
            repeat (w) @(posedge clk_i);
            count_o <= 1'b0; // falling edge arms the next rise
            repeat (w - 1) @(posedge clk_i);
        end
    endtask
endmodule

// >>> dv/tb.sv
// bench for the gated sixteen bit timer: bus tasks and directed tests
// assumes ext_source drives the count pin; the bench drives ticks, gate and sleep
`timescale 1ns/1ns
module tb;
    logic        clk_i = 1'b0;      // 25 MHz system clock
    logic        rst_i = 1'b1;      // synchronous reset, high
    logic        cyc   = 1'b0;      // bus request signals
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] dat   = 32'h0;
    logic [31:0] rdat;              // read data from the block
    logic        ack;
    logic        ext_pin;           // external count input from partner
    logic        lf_tick = 1'b0;    // slow oscillator tick
    logic        gate    = 1'b1;    // gate pin, high keeps polarity 0 closed
    logic        sleep   = 1'b0;
    logic        ovf;
    logic        wake;
    logic        wake_seen = 1'b0;  // wake pulse is one cycle, so latch it
    logic [31:0] got;
    int          err_count  = 0;
    int          n_compared = 0;
    int          cycles     = 0;

    gated_sixteen_bit_timer gated_sixteen_bit_timer_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .external_count_input_i(ext_pin), .low_freq_internal_osc_i(lf_tick),
        .gate_pin_i(gate), .sleep_i(sleep), .overflow_flag_o(ovf), .wake_o(wake)
    );
    ext_source ext_source_inst (.clk_i(clk_i), .count_o(ext_pin));

    // free-running clock
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // timeout guard and wake capture; ceiling well above the planned run
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (wake === 1'b1) wake_seen <= 1'b1;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic compare(input logic [31:0] g, input logic [31:0] e, input logic [31:0] tol);
        n_compared++;
        if (!(g >= e && g <= e + tol) || ((^g) === 1'bx)) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h (+%0d)", $time, g, e, tol);
        end
    endtask
    // classic cycle: hold everything until ack is sampled, then release
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] tol);
        bus(1'b0, a, 32'h0);
        compare(got, e, tol);
    endtask
    task automatic set_count(input logic [15:0] v);
        wr(gated_timer_pkg::ADDR_COUNT_LOW, v[7:0]);
        wr(gated_timer_pkg::ADDR_COUNT_HIGH, v[15:8]);
        repeat (4) @(posedge clk_i); // let the input synchroniser settle
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_i) lf_tick <= 1'b1;
            @(posedge clk_i) lf_tick <= 1'b0;
        end
    endtask
    // count measured over a window; bus overhead gives a small tolerance
    task automatic run_window(input logic [7:0] src, input logic [31:0] e, input logic [31:0] t);
        wr(gated_timer_pkg::ADDR_TIMER_CTRL, src);
        set_count(16'h0000);
        wr(gated_timer_pkg::ADDR_TIMER_CTRL, src | 8'h01);
        repeat (400) @(posedge clk_i);
        wr(gated_timer_pkg::ADDR_TIMER_CTRL, src);
        rd(gated_timer_pkg::ADDR_COUNT_LOW, e[7:0], t);
        rd(gated_timer_pkg::ADDR_COUNT_HIGH, e[15:8], 0);
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values and unmapped place
        rd(gated_timer_pkg::ADDR_TIMER_CTRL, 0, 0);
        rd(gated_timer_pkg::ADDR_GATE_CTRL, 0, 0);
        rd(gated_timer_pkg::ADDR_COUNT_LOW, 0, 0);
        rd(gated_timer_pkg::ADDR_STATUS, 0, 0);
        wr(8'h20, 8'h5a);
        rd(8'h20, 0, 0);
        $display("test reset done");
        // byte writes replace the count directly
        set_count(16'h1234);
        rd(gated_timer_pkg::ADDR_COUNT_LOW, 32'h34, 0);
        rd(gated_timer_pkg::ADDR_COUNT_HIGH, 32'h12, 0);
        // system clock +1 per clock, instruction clock +1 per four
        run_window(8'h40, 400, 12);
        run_window(8'h00, 100, 4);
        $display("test internal sources done");
        // every prescale code on the slow oscillator ticks
        for (int p = 0; p < 4; p++) begin
            wr(gated_timer_pkg::ADDR_TIMER_CTRL, 8'hc1 | (p << 4));
            set_count(16'h0000); // also clears the hidden prescaler
            ticks(16);
            rd(gated_timer_pkg::ADDR_COUNT_LOW, 16 >> p, 0);
        end
        $display("test prescaler done");
        // external input: first rise after the write is refused, then one per rise
        for (int s = 0; s < 2; s++) begin
            wr(gated_timer_pkg::ADDR_TIMER_CTRL, s ? 8'h85 : 8'h81);
            set_count(16'h0000);
            ext_source_inst.pulses(5, 4);
            repeat (4) @(posedge clk_i);
            rd(gated_timer_pkg::ADDR_COUNT_LOW, 4, 0);
        end
        $display("test external done");
        // timer off counts nothing even with the gate enabled
        wr(gated_timer_pkg::ADDR_GATE_CTRL, 8'h80);
        wr(gated_timer_pkg::ADDR_TIMER_CTRL, 8'h40);
        set_count(16'h0000);
        repeat (20) @(posedge clk_i);
        rd(gated_timer_pkg::ADDR_COUNT_LOW, 0, 0);
        // gate high with polarity 0 holds, polarity 1 counts
        wr(gated_timer_pkg::ADDR_TIMER_CTRL, 8'h41);
        repeat (20) @(posedge clk_i);
        rd(gated_timer_pkg::ADDR_COUNT_LOW, 0, 0);
        wr(gated_timer_pkg::ADDR_GATE_CTRL, 8'hc0); // gate pin stands in for an async event
        wr(gated_timer_pkg::ADDR_TIMER_CTRL, 8'h40);
        rd(gated_timer_pkg::ADDR_COUNT_LOW, 1, 10);
        rd(gated_timer_pkg::ADDR_STATUS, 2, 0);
        wr(gated_timer_pkg::ADDR_GATE_CTRL, 8'h00);
        $display("test gate done");
        // rollover sets the flag, write one clears it
        set_count(16'hffff);
        wr(gated_timer_pkg::ADDR_TIMER_CTRL, 8'h41);
        wr(gated_timer_pkg::ADDR_TIMER_CTRL, 8'h40);
        rd(gated_timer_pkg::ADDR_COUNT_LOW, 1, 8);
        rd(gated_timer_pkg::ADDR_STATUS, 1, 0);
        compare({31'h0, ovf}, 1, 0);
        wr(gated_timer_pkg::ADDR_STATUS, 8'h01);
        rd(gated_timer_pkg::ADDR_STATUS, 0, 0);
        // sleep: synchronous external counting stops
        wr(gated_timer_pkg::ADDR_TIMER_CTRL, 8'h81);
        set_count(16'hfffe);
        sleep <= 1'b1;
        ext_source_inst.pulses(4, 4);
        sleep <= 1'b0;
        rd(gated_timer_pkg::ADDR_COUNT_LOW, 32'hfe, 0);
        compare({31'h0, wake_seen}, 0, 0);
        // sleep: asynchronous external counting runs on and wakes on rollover
        wr(gated_timer_pkg::ADDR_TIMER_CTRL, 8'h85);
        set_count(16'hffff);
        sleep <= 1'b1;
        ext_source_inst.pulses(2, 4);
        repeat (4) @(posedge clk_i);
        sleep <= 1'b0;
        compare({31'h0, wake_seen}, 1, 0);
        rd(gated_timer_pkg::ADDR_COUNT_HIGH, 0, 0);
        rd(gated_timer_pkg::ADDR_STATUS, 1, 0);
        $display("test sleep done");
        finish_test();
    end
endmodule

// >>> include/gated_timer_pkg.sv
// constants for the gated sixteen bit timer: register map, fields, reset values
// assumes a 32-bit classic wishbone bus with word-aligned byte addresses
package gated_timer_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_COUNT_LOW   = 8'h00; // count_low_byte
    localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h04; // count_high_byte
    localparam logic [7:0] ADDR_TIMER_CTRL  = 8'h08; // timer_control_reg
    localparam logic [7:0] ADDR_GATE_CTRL   = 8'h0c; // gate_control_reg
    localparam logic [7:0] ADDR_STATUS      = 8'h10; // overflow flag, gate open (gate pin matches polarity)
    // timer_control_reg fields
    localparam int CTRL_ON_BIT    = 0;
    localparam int CTRL_SYNC_BIT  = 2;
    localparam int CTRL_PRE_LSB   = 4;
    localparam int CTRL_SRC_LSB   = 6;
    // gate_control_reg fields
    localparam int GATE_POL_BIT   = 6;
    localparam int GATE_EN_BIT    = 7;
    // status fields
    localparam int STAT_OVF_BIT   = 0;
    localparam int STAT_GATE_BIT  = 1;
    // reset values
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [7:0]  GATE_RESET  = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX   = 16'hffff;
    localparam logic [15:0] COUNT_ONE   = 16'h0001;
    // instruction clock is the system clock divided by four
    localparam logic [1:0]  QUARTER_LAST = 2'h3;
    localparam logic [1:0]  QUARTER_ONE  = 2'h1;
    localparam logic [2:0]  PRE_ONE      = 3'h1;
    localparam logic [2:0]  PRE_ZERO     = 3'h0;
    // clock source codes
    typedef enum logic [1:0] {
        SRC_INSTR = 2'h0,
        SRC_SYS   = 2'h1,
        SRC_EXT   = 2'h2,
        SRC_LFOSC = 2'h3
    } clock_source_type;
endpackage

// >>> logic/gated_sixteen_bit_timer.sv
// gated sixteen bit up-counter with source select, prescaler, gate and sleep
// assumes all inputs but external_count_input_i synchronous to clk_i (25 MHz); the low-frequency
// oscillator arrives as a one-cycle tick; sleep_i is high while the cpu sleeps
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns

module gated_sixteen_bit_timer (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        external_count_input_i,
    input  wire logic        low_freq_internal_osc_i,
    input  wire logic        gate_pin_i,
    input  wire logic        sleep_i,
    output logic             overflow_flag_o,
    output logic             wake_o
);
    // software visible state
    logic [15:0] count;          // running count
    logic [7:0]  timer_ctrl;     // timer_control_reg
    logic [7:0]  gate_ctrl;      // gate_control_reg
    logic        overflow_flag;  // sticky rollover flag
    // internal state
    logic [2:0]  pre_cnt;        // hidden prescale counter
    logic [1:0]  quarter;        // system clock divider for instruction clock
    logic        sync1;          // synchroniser first stage, read only by sync2
    logic        sync2;          // synchroniser second stage
    logic        sync_prev;      // previous synchronised level
    logic        raw_prev;       // previous raw level for the bypass path
    logic        armed;          // a falling edge has been seen

    // bus decode
    wire         bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire         bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
    wire         wr_low    = bus_wr & (wb_adr_i == gated_timer_pkg::ADDR_COUNT_LOW);
    wire         wr_high   = bus_wr & (wb_adr_i == gated_timer_pkg::ADDR_COUNT_HIGH);
    wire         wr_tctrl  = bus_wr & (wb_adr_i == gated_timer_pkg::ADDR_TIMER_CTRL);
    wire         wr_gctrl  = bus_wr & (wb_adr_i == gated_timer_pkg::ADDR_GATE_CTRL);
    wire         wr_stat   = bus_wr & (wb_adr_i == gated_timer_pkg::ADDR_STATUS);
    wire         cnt_wr    = wr_low | wr_high;

    // control fields
    wire         timer_on          = timer_ctrl[gated_timer_pkg::CTRL_ON_BIT];
    wire         sync_disable      = timer_ctrl[gated_timer_pkg::CTRL_SYNC_BIT];
    wire [1:0]   prescale_select   = timer_ctrl[gated_timer_pkg::CTRL_PRE_LSB +: 2];
    wire [1:0]   clock_source_select = timer_ctrl[gated_timer_pkg::CTRL_SRC_LSB +: 2];
    wire         gate_count_enable = gate_ctrl[gated_timer_pkg::GATE_EN_BIT];
    wire         gate_polarity     = gate_ctrl[gated_timer_pkg::GATE_POL_BIT];

    // last prescale count before a tick passes: 0, 1, 3 or 7
    function automatic logic [2:0] pre_mask(input logic [1:0] sel);
        pre_mask = 3'((4'h1 << sel) - 4'h1);
    endfunction

    // external edge detection; the bypass path skips the synchroniser
    wire         ext_level = sync_disable ? external_count_input_i : sync2;
    wire         ext_prev  = sync_disable ? raw_prev : sync_prev;
    wire         ext_rise  = ext_level & ~ext_prev;
    wire         ext_fall  = ~ext_level & ext_prev;
    wire         src_ext   = clock_source_select == gated_timer_pkg::SRC_EXT;
    wire         src_instr = clock_source_select == gated_timer_pkg::SRC_INSTR;
    wire         src_sys   = clock_source_select == gated_timer_pkg::SRC_SYS;
    wire         instr_tick = quarter == gated_timer_pkg::QUARTER_LAST;

    // source multiplexer: one enable per selected source event
    // a rise is only taken once a falling edge has armed the counter
    wire         src_tick  = src_instr ? instr_tick :
                             src_sys   ? 1'b1 :
                             src_ext   ? (ext_rise & armed) :
                                         low_freq_internal_osc_i;

    // gate level matches polarity: low with 0, high with 1
    wire         gate_ok   = gate_pin_i == gate_polarity;
    // only the unsynchronised external path keeps running in sleep
    wire         async_ext = src_ext & sync_disable;
    // off / always on / gated, per timer_on and gate enable
    wire         run       = timer_on & (~gate_count_enable | gate_ok)
                             & (~sleep_i | async_ext);
    // prescaler passes one tick in 1, 2, 4 or 8
    // a count left above a smaller new setting passes at once instead of
    // wrapping through all eight states first
    wire         pre_tick  = run & src_tick & (pre_cnt >= pre_mask(prescale_select));
    wire         inc       = pre_tick & ~cnt_wr;
    wire         rollover  = inc & (count == gated_timer_pkg::COUNT_MAX);

    // register read multiplexer; reserved bits and unmapped addresses read zero
    wire [31:0]  rd_data =
        (wb_adr_i == gated_timer_pkg::ADDR_COUNT_LOW)  ? {24'h000000, count[7:0]} :
        (wb_adr_i == gated_timer_pkg::ADDR_COUNT_HIGH) ? {24'h000000, count[15:8]} :
        (wb_adr_i == gated_timer_pkg::ADDR_TIMER_CTRL) ? {24'h000000, timer_ctrl} :
        (wb_adr_i == gated_timer_pkg::ADDR_GATE_CTRL)  ? {24'h000000, gate_ctrl} :
        (wb_adr_i == gated_timer_pkg::ADDR_STATUS)     ?
            {30'h0, gate_ok, overflow_flag} : 32'h00000000;

    // bus slave: one wait state, every address acknowledged
    // reads are registered from clocked state and gate_pin_i, so they are always stable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= rd_data;
        end
    end

    // control registers; reserved bits are kept at zero by the write masks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_ctrl <= gated_timer_pkg::CTRL_RESET;
            gate_ctrl  <= gated_timer_pkg::GATE_RESET;
        end else begin
            if (wr_tctrl) begin
                timer_ctrl <= wb_dat_i[7:0] & 8'hf5;
            end
            if (wr_gctrl) begin
                gate_ctrl <= wb_dat_i[7:0] & 8'hc0;
            end
        end
    end

    // count: a byte write wins over a coincident increment
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= gated_timer_pkg::COUNT_RESET;
        end else if (wr_low) begin
            count[7:0] <= wb_dat_i[7:0];
        end else if (wr_high) begin
            count[15:8] <= wb_dat_i[7:0];
        end else if (inc) begin
            count <= count + gated_timer_pkg::COUNT_ONE;
        end
    end

    // hidden prescaler, cleared by any count byte write
    always_ff @(posedge clk_i) begin
        if (rst_i || cnt_wr) begin
            pre_cnt <= gated_timer_pkg::PRE_ZERO;
        end else if (pre_tick) begin
            pre_cnt <= gated_timer_pkg::PRE_ZERO;
        end else if (run && src_tick) begin
            pre_cnt <= pre_cnt + gated_timer_pkg::PRE_ONE;
        end
    end

    // instruction clock divider, free running
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            quarter <= 2'h0;
        end else begin
            quarter <= quarter + gated_timer_pkg::QUARTER_ONE;
        end
    end

    // two-stage synchroniser plus history for both paths
    // changing sync_disable swaps history, so one count may be lost or
    // gained at the switch; this is accepted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1     <= 1'b0;
            sync2     <= 1'b0;
            sync_prev <= 1'b0;
            raw_prev  <= 1'b0;
        end else begin
            sync1     <= external_count_input_i;
            sync2     <= sync1;
            sync_prev <= sync2;
            raw_prev  <= external_count_input_i;
        end
    end

    // falling-edge arm: dropped on write or disable, set by a fall
    always_ff @(posedge clk_i) begin
        if (rst_i || cnt_wr || !timer_on) begin
            armed <= 1'b0;
        end else if (ext_fall) begin
            armed <= 1'b1;
        end
    end

    // overflow flag: rollover sets, writing 1 clears, set wins
    // wake pulse while asleep so the cpu can resume
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag   <= 1'b0;
            overflow_flag_o <= 1'b0;
            wake_o          <= 1'b0;
        end else begin
            if (rollover) begin
                overflow_flag <= 1'b1;
            end else if (wr_stat && wb_dat_i[gated_timer_pkg::STAT_OVF_BIT]) begin
                overflow_flag <= 1'b0;
            end
            overflow_flag_o <= rollover | overflow_flag;
            wake_o          <= rollover & sleep_i;
        end
    end

    // full resolution needs an asynchronous gate; software's concern

    // checks
    sequence s_quiet3;
        !inc ##1 !inc ##1 !inc;
    endsequence

    property p_write_low;
        @(posedge clk_i) disable iff (rst_i)
        wr_low |=> count[7:0] == $past(wb_dat_i[7:0]);
    endproperty
    a_write_low: assert property (p_write_low)
        else $error("low byte write not applied");

    property p_off_holds;
        @(posedge clk_i) disable iff (rst_i)
        (!timer_on && !cnt_wr) |=> count == $past(count);
    endproperty
    a_off_holds: assert property (p_off_holds)
        else $error("count moved while timer off");

    property p_sys_step;
        @(posedge clk_i) disable iff (rst_i)
        (run && src_sys && prescale_select == 2'h0 && !cnt_wr)
            |=> count == $past(count) + gated_timer_pkg::COUNT_ONE;
    endproperty
    a_sys_step: assert property (p_sys_step)
        else $error("system clock source did not step every cycle");

    property p_instr_rate;
        @(posedge clk_i) disable iff (rst_i)
        (inc && src_instr) |=> s_quiet3;
    endproperty
    a_instr_rate: assert property (p_instr_rate)
        else $error("instruction source counted faster than one in four");

    property p_armed;
        @(posedge clk_i) disable iff (rst_i)
        (src_ext && !armed) |-> !inc;
    endproperty
    a_armed: assert property (p_armed)
        else $error("rise counted before a falling edge");

    property p_pre_clear;
        @(posedge clk_i) disable iff (rst_i)
        cnt_wr |=> pre_cnt == gated_timer_pkg::PRE_ZERO;
    endproperty
    a_pre_clear: assert property (p_pre_clear)
        else $error("prescaler not cleared by count write");

    property p_pre_div;
        @(posedge clk_i) disable iff (rst_i)
        (run && src_tick && prescale_select == 2'h1 && pre_cnt == 3'h0 && !cnt_wr)
            |-> !inc;
    endproperty
    a_pre_div: assert property (p_pre_div)
        else $error("divide by two prescale passed an odd tick");

    property p_rollover;
        @(posedge clk_i) disable iff (rst_i)
        rollover |=> overflow_flag && count == gated_timer_pkg::COUNT_RESET;
    endproperty
    a_rollover: assert property (p_rollover)
        else $error("rollover did not set flag or clear count");

    property p_gate_hold;
        @(posedge clk_i) disable iff (rst_i)
        (gate_count_enable && !gate_ok && !cnt_wr) |=> $stable(count);
    endproperty
    a_gate_hold: assert property (p_gate_hold)
        else $error("count moved with gate closed");

    property p_sleep_hold;
        @(posedge clk_i) disable iff (rst_i)
        (sleep_i && !async_ext && !cnt_wr) |=> $stable(count);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("synchronous source counted in sleep");

    property p_sync_stages;
        @(posedge clk_i) disable iff (rst_i)
        $rose(sync2) |-> $past(external_count_input_i, 2);
    endproperty
    a_sync_stages: assert property (p_sync_stages)
        else $error("synchroniser is not two stages deep");
endmodule
